// [rtl/chip_control_unit_pkg.sv]
// Shared constants of the chip control unit: register map, fields,
// reset values, power modes and the slow tick timing.
// Assumes a 50 MHz core clock and a 32-bit AHB-Lite register port.
package chip_control_unit_pkg;

	// Register byte offsets, decoded on the low address byte
	localparam int         ADDR_W                  = 8;
	localparam logic [7:0] OFF_CHIP_IDENTITY       = 8'h00;
	localparam logic [7:0] OFF_PIN_PORT            = 8'h20;
	localparam logic [7:0] OFF_TWO_WIRE_MASTER     = 8'h2C;
	localparam logic [7:0] OFF_TWO_WIRE_SLAVE      = 8'h30;
	localparam logic [7:0] OFF_SERIAL_PORT         = 8'h34;
	localparam logic [7:0] OFF_TIMER               = 8'h38;
	localparam logic [7:0] OFF_FRONT_END           = 8'h3C;
	localparam logic [7:0] OFF_LOW_POWER_CFG       = 8'h60;
	localparam logic [7:0] OFF_LOW_POWER_CTRL      = 8'h64;
	localparam logic [7:0] OFF_MODE_STATUS         = 8'h70;

	// Peripheral slots, in the order of the control registers
	localparam int NUM_PERIPH      = 6;
	localparam int PERIPH_PIN_PORT = 0;
	localparam int PERIPH_FRONT_END = 5;

	// Per-peripheral control fields
	localparam int         BIT_RUN           = 0;
	localparam int         BIT_CLOCK_ON      = 1;
	localparam logic [1:0] PERIPH_CTRL_RESET = 2'h0;

	// Identity register fields
	localparam int IDENTITY_CODE_LSB = 16;
	localparam int REVISION_MSB      = 3;

	// Low-power configuration fields
	localparam int          SLEEP_COUNT_W    = 16;
	localparam int          PIN7_WAKE_BIT    = 16;
	localparam int          PIN8_WAKE_BIT    = 17;
	localparam logic [15:0] SLEEP_COUNT_RESET = 16'h0000;
	localparam logic        WAKE_EN_RESET    = 1'b0;

	// Low-power control request bits (write only)
	localparam int ENTER_DEEP_SLEEP_BIT = 0;
	localparam int ENTER_POWER_DOWN_BIT = 1;

	// Bus constants
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic       HRESP_OKAY    = 1'b0;

	// Slow deep-sleep tick derived from the core clock
	localparam int CORE_CLK_HZ      = 50_000_000;
	localparam int SLOW_CLK_HZ      = 512;
	localparam int SLOW_TICK_CYCLES = CORE_CLK_HZ / SLOW_CLK_HZ;

	// Operating modes
	typedef enum logic [1:0] {
		MODE_ACTIVE,
		MODE_SLEEP,
		MODE_DEEP_SLEEP,
		MODE_POWER_DOWN
	} power_mode_e;

endpackage

// [rtl/chip_control_unit.sv]
// Chip control unit: operating mode sequencer, wake-up logic, deep
// sleep countdown, per-peripheral run/clock gates and identity read.
// Assumes one AHB-Lite master, a processor on the same clock giving a
// wait-for-interrupt pulse and an interrupt level, and asynchronous
// wake pins.
//
// Summary of operation
// - Leave reset by itself in active mode
// - Only software moves active into low power
// - Wait-for-interrupt sleeps; any interrupt wakes
// - Deep sleep: fast clock off, processor reset
// - Power down: all off, registers reset except the pin wake enables, pins wake
// - High wake pin wakes when its enable set
// - Low wake pin wakes deep sleep if enabled
// - Low wake pin always wakes power down
// - Sequencer runs only in active or sleep
// - Each peripheral has run and clock bits
// - Peripheral reachable only when run and clocked
// - Bit0 run, bit1 clock, both reset zero
// - Front end needs run and clock set
// - Read-only identity code and revision
// - Writing one requests power down
// - Writing one requests deep sleep
// - Countdown from start value wakes if nonzero
// - Wake enables at bits 16 and 17
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/100ps

module chip_control_unit #(
	parameter int          SLOW_TICK_CYCLES =
		chip_control_unit_pkg::SLOW_TICK_CYCLES,
	parameter logic [15:0] IDENTITY_CODE    = 16'h5A3C, // Arbitrary value
	parameter logic [3:0]  REVISION         = 4'h1      // Arbitrary value
) (
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        wfi_executed,
	input  wire logic        irq_pending,
	input  wire logic        wake_pin_high_active,
	input  wire logic        wake_pin_low_active,
	output logic             internal_regulator_on,
	output logic             slow_osc_on,
	output logic             fast_osc_on,
	output logic             cpu_reset_n,
	output logic             cpu_idle,
	output logic             sequencer_enable,
	output logic      [5:0]  periph_run,
	output logic      [5:0]  periph_clock_on,
	output logic      [5:0]  periph_access_ok
);

	localparam int NP  = chip_control_unit_pkg::NUM_PERIPH;
	localparam int CW  = chip_control_unit_pkg::SLEEP_COUNT_W;
	localparam int DIV_W = $clog2(SLOW_TICK_CYCLES + 1);
	localparam logic [DIV_W-1:0] TICK_LAST =
		DIV_W'(SLOW_TICK_CYCLES - 1);

	// Peripheral offsets in slot order
	localparam logic [7:0] PERIPH_OFF [NP] = '{
		chip_control_unit_pkg::OFF_PIN_PORT,
		chip_control_unit_pkg::OFF_TWO_WIRE_MASTER,
		chip_control_unit_pkg::OFF_TWO_WIRE_SLAVE,
		chip_control_unit_pkg::OFF_SERIAL_PORT,
		chip_control_unit_pkg::OFF_TIMER,
		chip_control_unit_pkg::OFF_FRONT_END
	};

	// Reset release and pin synchronisers
	logic       rst_meta_q;     // First reset stage
	logic       rst_n;          // Released reset used everywhere
	logic [1:0] pin7_sync_q;    // High-active wake pin, two stages
	logic [1:0] pin8_sync_q;    // Low-active wake pin, two stages

	// Bus data-phase state
	logic            wr_pend_q, wr_pend_d;   // Write data phase pending
	logic [7:0]      wr_addr_q, wr_addr_d;   // Latched write offset
	logic [31:0]     rdata_q, rdata_d;       // Registered read data

	// Software-visible control
	logic [1:0]      periph_q [NP];          // Run/clock pairs
	logic [1:0]      periph_d [NP];
	logic [CW-1:0]   sleep_count_q, sleep_count_d; // Countdown start
	logic            pin7_en_q, pin7_en_d;   // High pin wake enable
	logic            pin8_en_q, pin8_en_d;   // Low pin wake enable

	// Mode sequencer and countdown
	chip_control_unit_pkg::power_mode_e mode_q, mode_d;
	logic [CW-1:0]   cnt_q, cnt_d;           // Deep sleep countdown
	logic            armed_q, armed_d;       // Nonzero start loaded
	logic [DIV_W-1:0] div_q, div_d;          // Slow tick divider
	logic [5:0]      mode_out_q, mode_out_d; // Registered mode outputs

	// Decoded write strobes, slow tick and wake pin levels
	logic            wr_hit;                 // Write lands this cycle
	logic            enter_deep;             // Deep sleep request
	logic            enter_down;             // Power down request
	logic            slow_tick;              // One 512 Hz tick
	logic            pin7_wake;              // Qualified high pin wake
	logic            pin8_low;               // Low pin asserted

	// Reset release: asynchronous assert, two-stage release
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_q <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n      <= rst_meta_q;
		end
	end

	// Wake pins come from outside and pass two synchroniser stages here
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin7_sync_q <= 2'h0;
			pin8_sync_q <= 2'h3;
		end else begin
			pin7_sync_q <= {pin7_sync_q[0], wake_pin_high_active};
			pin8_sync_q <= {pin8_sync_q[0], wake_pin_low_active};
		end
	end

	// Write strobes are decoded from the data phase only
	assign wr_hit     = wr_pend_q;
	assign enter_down = wr_hit && (mode_q == chip_control_unit_pkg::MODE_ACTIVE)
		&& (wr_addr_q == chip_control_unit_pkg::OFF_LOW_POWER_CTRL)
		&& hwdata[chip_control_unit_pkg::ENTER_POWER_DOWN_BIT];
	assign enter_deep = wr_hit && (mode_q == chip_control_unit_pkg::MODE_ACTIVE)
		&& (wr_addr_q == chip_control_unit_pkg::OFF_LOW_POWER_CTRL)
		&& hwdata[chip_control_unit_pkg::ENTER_DEEP_SLEEP_BIT];
	assign pin7_wake  = pin7_sync_q[1] && pin7_en_q;
	assign pin8_low   = !pin8_sync_q[1];
	assign slow_tick  = (div_q == TICK_LAST);

	// Mode, countdown and divider next state
	always_comb begin
		mode_d  = mode_q;
		cnt_d   = cnt_q;
		armed_d = armed_q;
		div_d   = '0;
		unique case (mode_q)
			chip_control_unit_pkg::MODE_ACTIVE: begin
				// Low power only on software request
				if (enter_down) begin
					mode_d = chip_control_unit_pkg::MODE_POWER_DOWN;
				end else if (enter_deep) begin
					mode_d  = chip_control_unit_pkg::MODE_DEEP_SLEEP;
					cnt_d   = sleep_count_q;
					armed_d = (sleep_count_q != '0);
				end else if (wfi_executed) begin
					mode_d = chip_control_unit_pkg::MODE_SLEEP;
				end
			end
			chip_control_unit_pkg::MODE_SLEEP: begin
				// Any pending interrupt resumes the processor
				if (irq_pending) begin
					mode_d = chip_control_unit_pkg::MODE_ACTIVE;
				end
			end
			chip_control_unit_pkg::MODE_DEEP_SLEEP: begin
				// Divider only runs here, where the countdown needs it
				div_d = slow_tick ? '0 : div_q + 1'b1;
				if (slow_tick && (cnt_q != '0)) begin
					cnt_d = cnt_q - 1'b1;
				end
				if ((armed_q && (cnt_q == '0)) || pin7_wake
					|| (pin8_low && pin8_en_q)) begin
					mode_d  = chip_control_unit_pkg::MODE_ACTIVE;
					armed_d = 1'b0;
				end
			end
			chip_control_unit_pkg::MODE_POWER_DOWN: begin
				// Low pin wakes regardless of its enable
				if (pin7_wake || pin8_low) begin
					mode_d = chip_control_unit_pkg::MODE_ACTIVE;
				end
			end
		endcase
		// Regulator, slow osc, fast osc, cpu run, idle, sequencer
		unique case (mode_d)
			chip_control_unit_pkg::MODE_ACTIVE:
				mode_out_d = 6'h3D;
			chip_control_unit_pkg::MODE_SLEEP:
				mode_out_d = 6'h3F;
			chip_control_unit_pkg::MODE_DEEP_SLEEP:
				mode_out_d = 6'h30;
			chip_control_unit_pkg::MODE_POWER_DOWN:
				mode_out_d = 6'h00;
		endcase
	end

	// Mode registers; reset lands straight in active mode
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q     <= chip_control_unit_pkg::MODE_ACTIVE;
			cnt_q      <= '0;
			armed_q    <= 1'b0;
			div_q      <= '0;
			mode_out_q <= 6'h3D;
		end else begin
			mode_q     <= mode_d;
			cnt_q      <= cnt_d;
			armed_q    <= armed_d;
			div_q      <= div_d;
			mode_out_q <= mode_out_d;
		end
	end

	assign internal_regulator_on = mode_out_q[5];
	assign slow_osc_on           = mode_out_q[4];
	assign fast_osc_on           = mode_out_q[3];
	assign cpu_reset_n           = mode_out_q[2];  // Low holds processor
	assign cpu_idle              = mode_out_q[1];
	assign sequencer_enable      = mode_out_q[0];

	// Register file, bus phases and read data next state
	always_comb begin
		logic [31:0] rd;
		rd             = 32'h0000_0000;
		wr_pend_d      = 1'b0;
		wr_addr_d      = wr_addr_q;
		periph_d       = periph_q;
		sleep_count_d  = sleep_count_q;
		pin7_en_d      = pin7_en_q;
		pin8_en_d      = pin8_en_q;
		// Data phase of a write: the peripheral pairs and config
		if (wr_hit) begin
			for (int i = 0; i < NP; i++) begin
				if (wr_addr_q == PERIPH_OFF[i]) begin
					periph_d[i] = hwdata[1:0];
				end
			end
			if (wr_addr_q == chip_control_unit_pkg::OFF_LOW_POWER_CFG) begin
				sleep_count_d = hwdata[CW-1:0];
				pin7_en_d = hwdata[chip_control_unit_pkg::PIN7_WAKE_BIT];
				pin8_en_d = hwdata[chip_control_unit_pkg::PIN8_WAKE_BIT];
			end
		end
		// Power down clears everything but the pin wake enables,
		// which must survive or the high pin could never wake it
		if (mode_d == chip_control_unit_pkg::MODE_POWER_DOWN) begin
			for (int i = 0; i < NP; i++) begin
				periph_d[i] = chip_control_unit_pkg::PERIPH_CTRL_RESET;
			end
			sleep_count_d = chip_control_unit_pkg::SLEEP_COUNT_RESET;
		end
		// Address phase: latch writes, build read data from the
		// next values so a read right after a write sees it
		if (hsel && hready && htrans[1]) begin
			if (hwrite) begin
				wr_pend_d = 1'b1;
				wr_addr_d = haddr[7:0];
			end else begin
				for (int i = 0; i < NP; i++) begin
					if (haddr[7:0] == PERIPH_OFF[i]) begin
						rd[1:0] = periph_d[i];
					end
				end
				unique case (haddr[7:0])
					chip_control_unit_pkg::OFF_CHIP_IDENTITY: begin
						rd[31:chip_control_unit_pkg::IDENTITY_CODE_LSB] =
							IDENTITY_CODE;
						rd[chip_control_unit_pkg::REVISION_MSB:0] =
							REVISION;
					end
					chip_control_unit_pkg::OFF_LOW_POWER_CFG: begin
						rd[CW-1:0] = sleep_count_d;
						rd[chip_control_unit_pkg::PIN7_WAKE_BIT] = pin7_en_d;
						rd[chip_control_unit_pkg::PIN8_WAKE_BIT] = pin8_en_d;
					end
					chip_control_unit_pkg::OFF_MODE_STATUS: begin
						rd[1:0] = mode_d;
					end
					default: begin
						// Unmapped and write-only offsets read zero
					end
				endcase
			end
		end
		rdata_d = rd;
	end

	// Register file flops; all controls clear on reset
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_pend_q     <= 1'b0;
			wr_addr_q     <= 8'h00;
			rdata_q       <= 32'h0000_0000;
			for (int i = 0; i < NP; i++) begin
				periph_q[i] <= chip_control_unit_pkg::PERIPH_CTRL_RESET;
			end
			sleep_count_q <= chip_control_unit_pkg::SLEEP_COUNT_RESET;
			pin7_en_q     <= chip_control_unit_pkg::WAKE_EN_RESET;
			pin8_en_q     <= chip_control_unit_pkg::WAKE_EN_RESET;
		end else begin
			wr_pend_q     <= wr_pend_d;
			wr_addr_q     <= wr_addr_d;
			rdata_q       <= rdata_d;
			periph_q      <= periph_d;
			sleep_count_q <= sleep_count_d;
			pin7_en_q     <= pin7_en_d;
			pin8_en_q     <= pin8_en_d;
		end
	end

	// Per-slot gates; access needs both run and clock
	for (genvar g = 0; g < NP; g++) begin : gen_periph
		assign periph_run[g]       =
			periph_q[g][chip_control_unit_pkg::BIT_RUN];
		assign periph_clock_on[g]  =
			periph_q[g][chip_control_unit_pkg::BIT_CLOCK_ON];
		assign periph_access_ok[g] = periph_run[g] && periph_clock_on[g];
	end

	// Zero-wait slave, always OKAY; hsize is accepted as a word
	assign hrdata    = rdata_q;
	assign hreadyout = 1'b1;
	assign hresp     = chip_control_unit_pkg::HRESP_OKAY;

endmodule

// [bench/chip_control_unit_monitor.sv]
// Checker for the chip control unit: mode outputs and peripheral gates.
// Assumes it is bound onto chip_control_unit and sees its ports only.
`timescale 1ns/100ps
module chip_control_unit_monitor (
	input wire logic       core_clk,
	input wire logic       reset_n,
	input wire logic       wfi_executed,
	input wire logic       irq_pending,
	input wire logic       wake_pin_low_active,
	input wire logic       internal_regulator_on,
	input wire logic       slow_osc_on,
	input wire logic       fast_osc_on,
	input wire logic       cpu_reset_n,
	input wire logic       cpu_idle,
	input wire logic       sequencer_enable,
	input wire logic [5:0] periph_run,
	input wire logic [5:0] periph_clock_on,
	input wire logic [5:0] periph_access_ok
);
	// One clock domain, so one clocking and one disable for all
	default clocking dc @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);

	chk_access_gate: assert property (
		periph_access_ok == (periph_run & periph_clock_on))
		else $error("access allowed without run and clock");
	chk_sleep_on: assert property (
		cpu_idle |-> fast_osc_on && cpu_reset_n && sequencer_enable)
		else $error("sleep mode turned something off");
	chk_irq_wake: assert property (
		cpu_idle && irq_pending |-> ##[1:2] !cpu_idle)
		else $error("interrupt did not end sleep");
	chk_wfi_sleep: assert property (
		fast_osc_on && !cpu_idle && wfi_executed && !irq_pending
		|-> ##[1:2] cpu_idle)
		else $error("wait for interrupt did not sleep");
	chk_deep_reset: assert property (
		!fast_osc_on |-> !cpu_reset_n && !cpu_idle)
		else $error("processor not held in reset");
	chk_seq_fast: assert property (
		sequencer_enable == fast_osc_on)
		else $error("sequencer runs without fast oscillator");
	chk_pd_off: assert property (
		!internal_regulator_on |-> !slow_osc_on && !fast_osc_on)
		else $error("oscillator left on in power down");
	chk_pd_clear: assert property (
		!internal_regulator_on |=> periph_run == 6'h00
		&& periph_clock_on == 6'h00)
		else $error("peripheral bits kept through power down");
	chk_low_wake: assert property (
		!internal_regulator_on && !wake_pin_low_active
		|-> ##[1:6] internal_regulator_on)
		else $error("low pin did not end power down");
endmodule

bind chip_control_unit chip_control_unit_monitor i_mon (
	.core_clk, .reset_n, .wfi_executed, .irq_pending,
	.wake_pin_low_active, .internal_regulator_on, .slow_osc_on,
	.fast_osc_on, .cpu_reset_n, .cpu_idle, .sequencer_enable,
	.periph_run, .periph_clock_on, .periph_access_ok
);

// [bench/chip_control_unit_tb.sv]
// Self-checking bench of the chip control unit through its bus port.
// Assumes the monitor is compiled first; one 50 MHz clock, no partner.
`timescale 1ns/100ps
module chip_control_unit_tb;
	localparam int          TICK = 4;        // Short slow tick for sim
	localparam logic [15:0] IDC  = 16'h2E71; // Arbitrary value
	localparam logic [3:0]  REV  = 4'h6;     // Arbitrary value
	// Mode outputs {regulator,slow,fast,cpu run,idle,sequencer}
	localparam logic [5:0]  M_ACT = 6'h3D, M_SLP = 6'h3F;
	localparam logic [5:0]  M_DEEP = 6'h30, M_OFF = 6'h00;
	// Control register places, in slot order
	localparam logic [7:0]  OFFS [6] = '{8'h20, 8'h2C, 8'h30, 8'h34,
		8'h38, 8'h3C};
	logic core_clk = 1'h0, reset_n = 1'h0, hsel = 1'h0, hwrite = 1'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd_q;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;           // Whole words only
	logic wfi_executed = 1'h0, irq_pending = 1'h0;
	logic wake_pin_high_active = 1'h0;   // Idle low
	logic wake_pin_low_active = 1'h1;    // Idle high
	logic hreadyout, hresp, internal_regulator_on, slow_osc_on;
	logic fast_osc_on, cpu_reset_n, cpu_idle, sequencer_enable;
	logic [5:0]  periph_run, periph_clock_on, periph_access_ok;
	logic [5:0]  mode_v;
	int err_count = 0;
	int n_tests = 0;
	int cycles = 0;
	assign mode_v = {internal_regulator_on, slow_osc_on, fast_osc_on,
		cpu_reset_n, cpu_idle, sequencer_enable};

	chip_control_unit #(.SLOW_TICK_CYCLES(TICK), .IDENTITY_CODE(IDC),
		.REVISION(REV)) i_dut (
		.core_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp,
		.wfi_executed, .irq_pending, .wake_pin_high_active,
		.wake_pin_low_active, .internal_regulator_on, .slow_osc_on,
		.fast_osc_on, .cpu_reset_n, .cpu_idle, .sequencer_enable,
		.periph_run, .periph_clock_on, .periph_access_ok
	);

	// Free-running clock
	always #10 core_clk = ~core_clk;

	// Hang guard, well above the few hundred cycles the run needs
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 4000) begin
			err_count++;
			end_sim();
		end
	end

	task automatic end_sim();
		$display("comparisons %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Let n edges pass, then settle past the edge before sampling
	task automatic wt(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	// Hold the phase until ready; sample before the edge to avoid races
	task automatic wait_rdy();
		logic rdy;
		do begin
			@(negedge core_clk);
			rdy = hreadyout;
			rd_q = hrdata;
			@(posedge core_clk);
		end while (rdy !== 1'h1);
	endtask

	// One single word transfer; read data left in rd_q
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge core_clk);
		hsel <= 1'h1;
		haddr <= {24'h0, a};
		htrans <= chip_control_unit_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		wait_rdy();
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'h0, a, 32'h0);
		chk(rd_q, e);
	endtask

	task automatic pins(input logic h, input logic l);
		@(posedge core_clk);
		wake_pin_high_active <= h;
		wake_pin_low_active <= l;
	endtask

	// Bounded wait for the fast oscillator to come back
	task automatic wake_wait(input int lim);
		int n;
		n = 0;
		while (fast_osc_on !== 1'h1 && n < lim) begin
			wt(1);
			n++;
		end
		chk(mode_v, M_ACT);
	endtask

	task automatic t_reset();
		chk(mode_v, M_ACT);
		chk({periph_run, periph_clock_on}, 12'h0);
		rdchk(8'h00, {IDC, 12'h0, REV});
		chk(hreadyout, 1'h1);
		chk(hresp, 1'h0);
		rdchk(8'h70, 32'h0);
		rdchk(8'h64, 32'h0);
		bus(1'h1, 8'h00, 32'hFFFFFFFF);
		rdchk(8'h00, {IDC, 12'h0, REV});
		rdchk(8'h80, 32'h0);
		foreach (OFFS[i]) rdchk(OFFS[i], 32'h0);
		$display("test reset done");
	endtask

	task automatic t_periph();
		for (int i = 0; i < 6; i++) begin
			for (int v = 1; v < 4; v++) begin
				bus(1'h1, OFFS[i], 32'(v));
				wt(1);
				chk({periph_run[i], periph_clock_on[i], periph_access_ok[i]},
					{v[0], v[1], v[0] & v[1]});
			end
			rdchk(OFFS[i], 32'h3);
		end
		chk(periph_access_ok, 6'h3F);
		$display("test peripheral gates done");
	endtask

	task automatic t_sleep();
		wt(20);
		chk(mode_v, M_ACT);
		@(posedge core_clk);
		wfi_executed <= 1'h1;
		@(posedge core_clk);
		wfi_executed <= 1'h0;
		wt(2);
		chk(mode_v, M_SLP);
		@(posedge core_clk);
		irq_pending <= 1'h1;
		@(posedge core_clk);
		irq_pending <= 1'h0;
		wt(2);
		chk(mode_v, M_ACT);
		$display("test sleep done");
	endtask

	task automatic t_deep();
		bus(1'h1, 8'h60, 32'h3);
		bus(1'h1, 8'h64, 32'h1);
		wt(1);
		chk(mode_v, M_DEEP);
		chk(periph_access_ok, 6'h3F);
		wt(4);
		chk(fast_osc_on, 1'h0);
		wake_wait(40);
		bus(1'h1, 8'h60, 32'h8);
		bus(1'h1, 8'h64, 32'h1);
		pins(1'h1, 1'h0);
		wt(10);
		chk(fast_osc_on, 1'h0);
		pins(1'h0, 1'h1);
		wake_wait(60);
		bus(1'h1, 8'h60, 32'h20000);
		bus(1'h1, 8'h64, 32'h1);
		wt(12);
		chk(fast_osc_on, 1'h0);
		pins(1'h0, 1'h0);
		wake_wait(10);
		pins(1'h0, 1'h1);
		bus(1'h1, 8'h60, 32'h10000);
		bus(1'h1, 8'h64, 32'h1);
		pins(1'h1, 1'h1);
		wake_wait(10);
		pins(1'h0, 1'h1);
		$display("test deep sleep done");
	endtask

	task automatic t_pdown();
		bus(1'h1, 8'h60, 32'h10005);
		bus(1'h1, 8'h64, 32'h2);
		wt(1);
		chk(mode_v, M_OFF);
		wt(30);
		chk(mode_v, M_OFF);
		pins(1'h1, 1'h1);
		wake_wait(10);
		pins(1'h0, 1'h1);
		chk({periph_run, periph_clock_on}, 12'h0);
		rdchk(OFFS[5], 32'h0);
		// Count cleared by power down, pin enables kept on purpose
		rdchk(8'h60, 32'h10000);
		bus(1'h1, 8'h60, 32'h0);
		bus(1'h1, 8'h64, 32'h3);
		wt(1);
		chk(mode_v, M_OFF);
		pins(1'h0, 1'h0);
		wake_wait(10);
		pins(1'h0, 1'h1);
		$display("test power down done");
	endtask

	// Mid-run reset: controls must clear and the bus work again
	task automatic t_rerun();
		bus(1'h1, OFFS[2], 32'h3);
		bus(1'h1, 8'h60, 32'h30007);
		@(posedge core_clk);
		reset_n <= 1'h0;
		wt(2);
		chk(mode_v, M_ACT);
		chk({periph_run, periph_clock_on}, 12'h0);
		@(posedge core_clk);
		reset_n <= 1'h1;
		wt(3);
		rdchk(8'h60, 32'h0);
		rdchk(OFFS[2], 32'h0);
		chk(mode_v, M_ACT);
		$display("test second reset done");
	endtask

	// Main sequence: reset, then each scenario in turn
	initial begin
		repeat (12) @(posedge core_clk);
		reset_n <= 1'h1;
		wt(3);
		t_reset();
		t_periph();
		t_sleep();
		t_deep();
		t_pdown();
		t_rerun();
		end_sim();
	end
endmodule
